// ===== hw/uwl_pkg.sv
// shared constants and carriers for the unaligned word load merge
package uwl_pkg;
	// ----------------------------------------
	// instruction encoding
	// ----------------------------------------
	localparam logic [5:0] OP_LOAD_WORD_LEFT = 6'h22;
	localparam logic [5:0] OP_LOAD_WORD_RIGHT = 6'h26;
	localparam int OPC_HI = 31;
	localparam int OPC_LO = 26;
	localparam int BASE_HI = 25;
	localparam int BASE_LO = 21;
	localparam int TGT_HI = 20;
	localparam int TGT_LO = 16;
	localparam int DISP_HI = 15;
	localparam int DISP_LO = 0;
	// ----------------------------------------
	// widths and constants
	// ----------------------------------------
	localparam int XLEN = 64;
	localparam int WLEN = 32;
	localparam int DISP_W = 16;
	localparam logic [1:0] BYTE_MAX = 2'h3;
	localparam logic [2:0] OFS_ZERO = 3'h0;
	localparam logic [XLEN-1:0] REG_RST = 64'h0000_0000_0000_0000;
	localparam logic [WLEN-1:0] WORD_ZERO = 32'h0000_0000;

	typedef enum logic [1:0] {
		UWL_IDLE = 2'b01,
		UWL_WAIT = 2'b10
	} uwl_state_e;

	// request sent to the memory access path
	typedef struct packed {
		logic [XLEN-1:0] virtual_addr;
		logic [2:0] offset;
		logic [1:0] size;
	} uwl_mem_req_s;

	// result written to the general register file
	typedef struct packed {
		logic [4:0] idx;
		logic [XLEN-1:0] data;
	} uwl_wb_s;
endpackage : uwl_pkg

// ===== hw/uwl_merge.sv
// load word left / right address, request and byte merge datapath
//
// What this block does
// - decode left/right load opcode, base, target, displacement
// - address is base plus sign-extended displacement
// - fetch only the aligned word holding start
// - right load fills low bytes, keeps high
// - 64-bit mode sign-extends merged word
// - target register forwarded from preceding load
// - no alignment address error ever raised
// - left load, little memory: clear two bits
// - right load, big memory: clear three bits
// - left load size equals low byte index
// - left load upper half copies bit 31 in 64-bit mode only
// - left load fills high bytes, keeps low
`timescale 1ns/100ps
module uwl_merge (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic issue_valid_i,
	input wire logic [31:0] issue_instr_i,
	input wire logic [63:0] base_value_i,
	input wire logic [63:0] target_value_i,
	input wire logic mode64_i,
	input wire logic memory_big_endian_flag_i,
	input wire logic core_big_endian_flag_i,
	input wire logic user_byte_order_flip_i,
	input wire logic ld_wb_valid_i,
	input wire uwl_pkg::uwl_wb_s ld_wb_i,
	input wire logic mem_rsp_valid_i,
	input wire logic [63:0] mem_rdata_i,
	output logic issue_ready_o,
	output logic mem_req_valid_o,
	output uwl_pkg::uwl_mem_req_s mem_req_o,
	output logic wb_valid_o,
	output uwl_pkg::uwl_wb_s wb_o
);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] lane_merge(input logic left,
			input logic [1:0] b, input logic [31:0] mw,
			input logic [31:0] old);
		logic [31:0] r;
		logic [1:0] src;
		r = old;
		for (int k = 0; k < 4; k++) begin
			if (left) begin
				src = 2'(k + int'(b) + 1);
				if (k + int'(b) >= int'(uwl_pkg::BYTE_MAX)) begin
					r[8*k +: 8] = mw[8*src +: 8];
				end
			end else begin
				src = 2'(k + int'(b));
				if (k + int'(b) <= int'(uwl_pkg::BYTE_MAX)) begin
					r[8*k +: 8] = mw[8*src +: 8];
				end
			end
		end
		return r;
	endfunction : lane_merge

	// ----------------------------------------
	// decode and address
	// ----------------------------------------
	logic [5:0] opc;
	logic is_left;
	logic accept;
	logic [63:0] virtual_addr_nxt;
	logic [1:0] byte_idx;
	logic [2:0] ofs_nxt;
	logic [1:0] size_nxt;
	logic [4:0] tgt;
	logic [63:0] old_nxt;
	uwl_pkg::uwl_state_e state_r;

	assign opc = issue_instr_i[uwl_pkg::OPC_HI:uwl_pkg::OPC_LO];
	assign is_left = (opc == uwl_pkg::OP_LOAD_WORD_LEFT);
	assign tgt = issue_instr_i[uwl_pkg::TGT_HI:uwl_pkg::TGT_LO];
	assign accept = issue_valid_i && (state_r == uwl_pkg::UWL_IDLE) &&
		(is_left || opc == uwl_pkg::OP_LOAD_WORD_RIGHT);
	// any byte address is legal: no alignment check exists here
	assign virtual_addr_nxt = base_value_i + {{(64 - uwl_pkg::DISP_W)
		{issue_instr_i[uwl_pkg::DISP_HI]}},
		issue_instr_i[uwl_pkg::DISP_HI:uwl_pkg::DISP_LO]};
	assign byte_idx = virtual_addr_nxt[1:0] ^ {2{core_big_endian_flag_i}};

	always_comb begin
		ofs_nxt = virtual_addr_nxt[2:0] ^ {3{user_byte_order_flip_i}};
		if (is_left) begin
			size_nxt = byte_idx;
			if (!memory_big_endian_flag_i) begin
				ofs_nxt[1:0] = uwl_pkg::OFS_ZERO[1:0];
			end
		end else begin
			size_nxt = uwl_pkg::BYTE_MAX - byte_idx;
			if (memory_big_endian_flag_i) begin
				ofs_nxt = uwl_pkg::OFS_ZERO;
			end
		end
	end

	// newest value wins: own result, then other load result, then file
	always_comb begin
		if (wb_valid_o && wb_o.idx == tgt) begin
			old_nxt = wb_o.data;
		end else if (ld_wb_valid_i && ld_wb_i.idx == tgt) begin
			old_nxt = ld_wb_i.data;
		end else begin
			old_nxt = target_value_i;
		end
	end

	// ----------------------------------------
	// control
	// ----------------------------------------
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_r <= uwl_pkg::UWL_IDLE;
			issue_ready_o <= 1'b1;
		end else begin
			case (state_r)
				uwl_pkg::UWL_IDLE: begin
					if (accept) begin
						state_r <= uwl_pkg::UWL_WAIT;
						issue_ready_o <= 1'b0;
					end
				end
				uwl_pkg::UWL_WAIT: begin
					if (mem_rsp_valid_i) begin
						state_r <= uwl_pkg::UWL_IDLE;
						issue_ready_o <= 1'b1;
					end
				end
				default: begin
					state_r <= uwl_pkg::UWL_IDLE;
					issue_ready_o <= 1'b1;
				end
			endcase
		end
	end

	// ----------------------------------------
	// memory request and pending operands
	// ----------------------------------------
	logic left_r;
	logic mode64_r;
	logic [1:0] byte_r;
	logic word_r;
	logic [4:0] tgt_r;
	logic [63:0] old_r;

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mem_req_valid_o <= 1'b0;
			mem_req_o <= '0;
		end else begin
			mem_req_valid_o <= accept;
			if (accept) begin
				mem_req_o.virtual_addr <= virtual_addr_nxt;
				mem_req_o.offset <= ofs_nxt;
				mem_req_o.size <= size_nxt;
			end
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			left_r <= 1'b0;
			mode64_r <= 1'b0;
			byte_r <= 2'h0;
			word_r <= 1'b0;
			tgt_r <= 5'h00;
			old_r <= uwl_pkg::REG_RST;
		end else if (accept) begin
			left_r <= is_left;
			mode64_r <= mode64_i;
			byte_r <= byte_idx;
			word_r <= virtual_addr_nxt[2] ^ core_big_endian_flag_i;
			tgt_r <= tgt;
			old_r <= old_nxt;
		end else if (ld_wb_valid_i && ld_wb_i.idx == tgt_r &&
				state_r == uwl_pkg::UWL_WAIT) begin
			old_r <= ld_wb_i.data;
		end
	end

	// ----------------------------------------
	// merge and write back
	// ----------------------------------------
	logic [63:0] old_use;
	logic [31:0] mem_word;
	logic [31:0] merged;

	// a load landing in the answer cycle is newer than old_r, so it wins
	always_comb begin
		if (ld_wb_valid_i && ld_wb_i.idx == tgt_r &&
				state_r == uwl_pkg::UWL_WAIT) begin
			old_use = ld_wb_i.data;
		end else begin
			old_use = old_r;
		end
	end

	// only the aligned word holding the start byte is used
	assign mem_word = word_r ? mem_rdata_i[63:32] : mem_rdata_i[31:0];
	assign merged = lane_merge(left_r, byte_r, mem_word, old_use[31:0]);

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wb_valid_o <= 1'b0;
			wb_o <= '0;
		end else begin
			wb_valid_o <= mem_rsp_valid_i && state_r == uwl_pkg::UWL_WAIT;
			if (mem_rsp_valid_i && state_r == uwl_pkg::UWL_WAIT) begin
				wb_o.idx <= tgt_r;
				// 32-bit mode leaves the upper half untouched
				if (mode64_r) begin
					wb_o.data <= {{32{merged[31]}}, merged};
				end else begin
					wb_o.data <= {old_use[63:32], merged};
				end
			end
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);

	a_req_follows_issue: assert property (
		accept |=> mem_req_valid_o && !issue_ready_o)
		else $error("request missing after issue");
	a_addr_sum: assert property (
		accept |=> mem_req_o.virtual_addr == $past(base_value_i) +
		{{48{$past(issue_instr_i[15])}}, $past(issue_instr_i[15:0])})
		else $error("effective address wrong");
	a_left_le_clear: assert property (
		accept && is_left && !memory_big_endian_flag_i
		|=> mem_req_o.offset[1:0] == 2'h0)
		else $error("left load offset not cleared");
	a_right_be_clear: assert property (
		accept && !is_left && memory_big_endian_flag_i
		|=> mem_req_o.offset == 3'h0)
		else $error("right load offset not cleared");
	a_left_size: assert property (
		accept && is_left && !core_big_endian_flag_i
		|=> mem_req_o.size == mem_req_o.virtual_addr[1:0])
		else $error("left load size wrong");
	a_sign_extend: assert property (
		wb_valid_o && $past(mode64_r)
		|-> wb_o.data[63:32] == {32{wb_o.data[31]}})
		else $error("result not sign extended");
	a_wb_after_rsp: assert property (
		mem_rsp_valid_i && state_r == uwl_pkg::UWL_WAIT
		|=> wb_valid_o && issue_ready_o && wb_o.idx == $past(tgt_r))
		else $error("write back missing");
	a_right_full_word: assert property (
		mem_rsp_valid_i && state_r == uwl_pkg::UWL_WAIT && !left_r &&
		byte_r == 2'h0 && !word_r |=> wb_o.data[31:0] ==
		$past(mem_rdata_i[31:0]))
		else $error("right load full word wrong");
	a_left_keep_low: assert property (
		mem_rsp_valid_i && state_r == uwl_pkg::UWL_WAIT && left_r &&
		byte_r == 2'h0 |=> wb_o.data[23:0] == $past(old_use[23:0]))
		else $error("left load low bytes changed");
	a_forward_own: assert property (
		accept && wb_valid_o && wb_o.idx == tgt |=> old_r == $past(wb_o.data))
		else $error("target not forwarded");
	a_req_pulse: assert property (
		mem_req_valid_o |=> !mem_req_valid_o)
		else $error("request held too long");
	a_wb_pulse: assert property (
		wb_valid_o |=> !wb_valid_o)
		else $error("write back held too long");
	a_right_size: assert property (
		accept && !is_left && !core_big_endian_flag_i
		|=> mem_req_o.size == ~mem_req_o.virtual_addr[1:0])
		else $error("right load size wrong");
	a_left_ofs_word: assert property (
		accept && is_left && !memory_big_endian_flag_i &&
		!user_byte_order_flip_i
		|=> mem_req_o.offset == {mem_req_o.virtual_addr[2], 2'h0})
		else $error("left load word offset wrong");
	a_left_full_word: assert property (
		mem_rsp_valid_i && state_r == uwl_pkg::UWL_WAIT && left_r &&
		byte_r == 2'h3 |=> wb_o.data[31:0] == $past(mem_word))
		else $error("left load full word wrong");
	a_right_keep_high: assert property (
		mem_rsp_valid_i && state_r == uwl_pkg::UWL_WAIT && !left_r &&
		byte_r == 2'h3 |=> wb_o.data[31:8] == $past(old_use[31:8]))
		else $error("right load high bytes changed");
	a_keep_upper32: assert property (
		mem_rsp_valid_i && state_r == uwl_pkg::UWL_WAIT && !mode64_r
		|=> wb_o.data[63:32] == $past(old_use[63:32]))
		else $error("upper half changed in 32-bit mode");
	a_busy_refused: assert property (
		issue_valid_i && !issue_ready_o |=> !mem_req_valid_o)
		else $error("request started while busy");
	a_forward_other: assert property (
		accept && ld_wb_valid_i && ld_wb_i.idx == tgt &&
		!(wb_valid_o && wb_o.idx == tgt) |=> old_r == $past(ld_wb_i.data))
		else $error("other load not forwarded");
	a_wait_forward: assert property (
		ld_wb_valid_i && ld_wb_i.idx == tgt_r &&
		state_r == uwl_pkg::UWL_WAIT |=> old_r == $past(ld_wb_i.data))
		else $error("pending target not updated");
endmodule : uwl_merge

// ===== verif/uwl_mem_model.sv
// memory access path model answering word load requests
`timescale 1ns/100ps
module uwl_mem_model #(
	parameter logic [63:0] MEM_DATA = 64'h8192_a3b4_c5d6_e7f8
) (
	input wire logic mclk_i,
	input wire logic slow_i,
	input wire logic req_valid_i,
	output logic rsp_valid_o,
	output logic [63:0] rdata_o
);
	// idle data is inverted so a stale read can never look right
	initial begin
		rsp_valid_o = 1'b0;
		rdata_o = ~MEM_DATA;
		forever begin
			@(posedge mclk_i);
			if (req_valid_i) begin
				repeat (slow_i ? 6 : 0) @(posedge mclk_i);
				rsp_valid_o <= 1'b1;
				rdata_o <= MEM_DATA;
				@(posedge mclk_i);
				rsp_valid_o <= 1'b0;
				rdata_o <= ~MEM_DATA;
			end
		end
	end
endmodule : uwl_mem_model

// ===== verif/uwl_merge_tb.sv
// self-checking bench for the unaligned word load merge
`timescale 1ns/100ps
module uwl_merge_tb;
	localparam logic [63:0] MEM = 64'h8192_a3b4_c5d6_e7f8;
	localparam logic [63:0] TGT = 64'h0f1e_2d3c_4b5a_6978;
	localparam logic [63:0] FWD = 64'h7766_5544_3322_1100;
	logic mclk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic issue_valid_i = 1'b0;
	logic [31:0] issue_instr_i = 32'h0000_0000;
	logic mode64_i = 1'b1;
	logic mem_be = 1'b0;
	logic core_be = 1'b0;
	logic flip = 1'b0;
	logic slow = 1'b0;
	logic ld_wb_valid_i = 1'b0;
	uwl_pkg::uwl_wb_s ld_wb_i = '0;
	logic mem_rsp_valid_i;
	logic [63:0] mem_rdata_i;
	logic issue_ready_o, mem_req_valid_o, wb_valid_o;
	uwl_pkg::uwl_mem_req_s mem_req_o;
	uwl_pkg::uwl_wb_s wb_o;
	logic [63:0] general_register_file;
	int n_mismatch = 0;
	int n_checks = 0;

	uwl_merge u_dut (
		.mclk_i(mclk_i), .rst_n_i(rst_n_i), .issue_valid_i(issue_valid_i),
		.issue_instr_i(issue_instr_i), .base_value_i(64'h0000_0000_0000_1000),
		.target_value_i(TGT), .mode64_i(mode64_i),
		.memory_big_endian_flag_i(mem_be), .core_big_endian_flag_i(core_be),
		.user_byte_order_flip_i(flip), .ld_wb_valid_i(ld_wb_valid_i),
		.ld_wb_i(ld_wb_i), .mem_rsp_valid_i(mem_rsp_valid_i),
		.mem_rdata_i(mem_rdata_i), .issue_ready_o(issue_ready_o),
		.mem_req_valid_o(mem_req_valid_o), .mem_req_o(mem_req_o),
		.wb_valid_o(wb_valid_o), .wb_o(wb_o)
	);

	uwl_mem_model #(.MEM_DATA(MEM)) u_mem (
		.mclk_i(mclk_i), .slow_i(slow), .req_valid_i(mem_req_valid_o),
		.rsp_valid_o(mem_rsp_valid_i), .rdata_o(mem_rdata_i)
	);

	always #4 mclk_i = ~mclk_i;

	task automatic check(input string what, input logic [63:0] got,
		input logic [63:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask : check

	function automatic logic [63:0] merge(input logic lf,
		input logic [1:0] b, input logic w, input logic [63:0] old);
		logic [31:0] mw;
		logic [63:0] r;
		int bi;
		mw = w ? MEM[63:32] : MEM[31:0];
		r = old;
		bi = b;
		for (int k = 0; k < 4; k++) begin
			if (lf && k >= 3 - bi) r[8*k +: 8] = mw[8*(k+bi-3) +: 8];
			if (!lf && k <= 3 - bi) r[8*k +: 8] = mw[8*(bi+k) +: 8];
		end
		if (mode64_i) r[63:32] = {32{r[31]}};
		return r;
	endfunction : merge

	// entered at a falling edge; returns where the writeback is visible
	task automatic do_load(input logic [5:0] op, input logic [2:0] a,
		input logic fv, input logic [4:0] fidx, input logic [63:0] old);
		logic lf;
		logic [1:0] b;
		logic [2:0] ofs;
		int n;
		lf = op === uwl_pkg::OP_LOAD_WORD_LEFT;
		b = a[1:0] ^ {2{core_be}};
		ofs = a ^ {3{flip}};
		if (lf && !mem_be) ofs[1:0] = 2'h0;
		if (!lf && mem_be) ofs = 3'h0;
		issue_valid_i = 1'b1;
		issue_instr_i = {op, 5'h01, 5'h07, 13'h1fff, a};
		ld_wb_valid_i = fv;
		ld_wb_i.idx = fidx;
		ld_wb_i.data = FWD;
		@(negedge mclk_i);
		issue_valid_i = 1'b0;
		ld_wb_valid_i = 1'b0;
		check("req_valid", mem_req_valid_o, 1'b1);
		check("virtual_addr", mem_req_o.virtual_addr, 64'h0000_0000_0000_0ff8 + a);
		check("offset", mem_req_o.offset, ofs);
		check("size", mem_req_o.size, lf ? b : 2'h3 - b);
		n = 0;
		while (wb_valid_o !== 1'b1 && n < 40) begin
			@(negedge mclk_i);
			n++;
		end
		check("wb_valid", wb_valid_o, 1'b1);
		general_register_file = merge(lf, b, a[2] ^ core_be, old);
		check("wb_idx", wb_o.idx, 5'h07);
		check("wb_data", wb_o.data, general_register_file);
	endtask : do_load

	// back to back, so each load after the first merges with the one before it
	task automatic sweep_all();
		for (int i = 0; i < 64; i++) begin
			mem_be = i[4];
			core_be = i[5];
			mode64_i = i[0] ^ i[3];
			flip = i[1] ^ i[4];
			slow = i[5];
			do_load(i[3] ? 6'h22 : 6'h26, i[2:0], 1'b0, 5'h00, general_register_file);
		end
	endtask : sweep_all

	task automatic fwd_other_load();
		@(negedge mclk_i);
		do_load(6'h22, 3'h5, 1'b1, 5'h07, FWD);
		@(negedge mclk_i);
		do_load(6'h26, 3'h2, 1'b1, 5'h08, TGT);
	endtask : fwd_other_load

	// another load lands while the answer is pending; lag picks the cycle
	task automatic fwd_while_wait(input int lag);
		@(negedge mclk_i);
		slow = 1'b1;
		fork
			do_load(6'h26, 3'h1, 1'b0, 5'h07, FWD);
			begin
				repeat (lag) @(negedge mclk_i);
				ld_wb_valid_i = 1'b1;
				@(negedge mclk_i);
				ld_wb_valid_i = 1'b0;
			end
		join
	endtask : fwd_while_wait

	// a second issue while busy is ignored, only the first one completes
	task automatic refused_busy();
		@(negedge mclk_i);
		issue_valid_i = 1'b1;
		issue_instr_i = {6'h22, 5'h01, 5'h09, 16'hfff9};
		@(negedge mclk_i);
		check("ready", issue_ready_o, 1'b0);
		issue_instr_i = {6'h26, 5'h01, 5'h0a, 16'hfffa};
		@(negedge mclk_i);
		issue_valid_i = 1'b0;
		check("req_valid", mem_req_valid_o, 1'b0);
		repeat (10) @(negedge mclk_i);
		check("wb_idx", wb_o.idx, 5'h09);
		check("ready", issue_ready_o, 1'b1);
	endtask : refused_busy

	task automatic refused_opcode();
		@(negedge mclk_i);
		issue_valid_i = 1'b1;
		issue_instr_i = 32'h8c00_0000;
		@(negedge mclk_i);
		issue_valid_i = 1'b0;
		check("req_valid", mem_req_valid_o, 1'b0);
		check("ready", issue_ready_o, 1'b1);
	endtask : refused_opcode

	task automatic finish_test();
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : finish_test

	initial begin
		general_register_file = TGT;
		repeat (20) @(negedge mclk_i);
		rst_n_i = 1'b1;
		@(negedge mclk_i);
		sweep_all();
		fwd_other_load();
		fwd_while_wait(3);
		fwd_while_wait(8);
		refused_busy();
		refused_opcode();
		finish_test();
	end

	// about ten times the longest expected run
	initial begin
		#40000;
		n_mismatch++;
		finish_test();
	end
endmodule : uwl_merge_tb
